// File: include/fbf_pkg.sv
// shared constants for fixed-block format control
package fbf_pkg;
	localparam int LIST_OCTETS = 32;
	localparam logic [15:0] LIST_LEN = 16'h001e;
	localparam logic [7:0] TYPE_FIXED = 8'h01;
	localparam int OFS_LEN = 0;
	localparam int OFS_TYPE = 2;
	localparam int OFS_FLAG = 3;
	localparam int OFS_SECTORS = 4;
	localparam int OFS_PHYS = 6;
	localparam int OFS_SKIP = 10;
	localparam int OFS_FIELDS = 12;
	localparam int OFS_SIZE0 = 14;
	localparam int OFS_DLY0 = 18;
	localparam int FIELD_STRIDE = 6;
	localparam int FLG_INIT = 7;
	localparam int FLG_MAKER = 6;
	localparam int FLG_MODE2 = 5;
	localparam int FLG_MODE1 = 4;
	localparam int FLG_SOFT = 3;
	localparam int FLG_HARD = 2;
	localparam int FLG_FIELD = 1;
	localparam int FLG_SECTOR = 0;
	localparam int MAX_FIELDS = 3;
	localparam int MAX_SECTORS = 256;
	localparam int SYNC_SEG = 1;
	localparam int PAD_SEG = 2;
	localparam logic [7:0] SYNC_OCTET = 8'ha1;
	localparam logic [7:0] PLO_OCTET = 8'h00;
	localparam logic [7:0] PAD_OCTET = 8'h00;
	localparam logic [15:0] UNSPEC16 = 16'hffff;
	localparam logic [31:0] UNSPEC32 = 32'hffff_ffff;
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_READ = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_VERIFY = 2'h3;
	localparam logic [7:0] REG_LIST0 = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h20;
	localparam logic [7:0] REG_STAT = 8'h24;
	localparam logic [7:0] REG_WDATA = 8'h28;
	localparam logic [7:0] REG_RDATA = 8'h2c;
	localparam int CMD_GO_LOAD = 4;
	localparam int CMD_GO_READ = 5;
endpackage

// File: include/fbf_if.sv
// link between the disk controller and the drive format control
`timescale 1ns/10ps
interface fbf_if;
	logic listValid;
	logic listWrite;
	logic [4:0] listAddr;
	logic [7:0] listWdata;
	logic listReady;
	logic listRvalid;
	logic [7:0] listRdata;
	logic listDone;
	logic [1:0] cmdOp;
	logic [1:0] cmdField;
	logic [7:0] wrData;
	logic rdValid;
	logic [7:0] rdOctet;
	logic cmpEn;
	logic slaveIn;
	logic fmtOk;
	modport drive(input listValid, listWrite, listAddr, listWdata, listDone, cmdOp, cmdField,
		wrData, output listReady, listRvalid, listRdata, rdValid, rdOctet, cmpEn, slaveIn, fmtOk);
	modport ctrl(output listValid, listWrite, listAddr, listWdata, listDone, cmdOp, cmdField,
		wrData, input listReady, listRvalid, listRdata, rdValid, rdOctet, cmpEn, slaveIn, fmtOk);
endinterface

// File: hw/fbf_divider.sv
// sequential restoring divider, one quotient bit per enabled cycle
`timescale 1ns/10ps
module fbf_divider #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic done,
	output logic [W-1:0] quot
);
	logic [W-1:0] rem_q;
	logic [W-1:0] num_q;
	logic [W-1:0] den_q;
	logic [$clog2(W+1)-1:0] cnt_q;
	logic busy_q;
	logic [W:0] trial;

	assign trial = {rem_q, num_q[W-1]} - {1'b0, den_q};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rem_q <= '0;
			num_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done <= 1'b0;
			quot <= '0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				rem_q <= '0;
				num_q <= num;
				den_q <= den;
				cnt_q <= '0;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				// a zero divisor gives all ones, which only the sector count caller clips
				if (!trial[W]) begin
					rem_q <= trial[W-1:0];
				end else begin
					rem_q <= {rem_q[W-2:0], num_q[W-1]};
				end
				num_q <= {num_q[W-2:0], !trial[W]};
				cnt_q <= cnt_q + 1'b1;
				if (cnt_q == ($clog2(W+1))'(W - 1)) begin
					busy_q <= 1'b0;
					done <= 1'b1;
					quot <= {num_q[W-2:0], !trial[W]};
				end
			end
		end
	end
endmodule

// File: hw/fbf_drive.sv
// drive end: format parameter list, sector/field sequencing, gates
//
// Operation
// - one known sync octet written, used for alignment
// - two pad octets before write gate off
// - data segment sized from list field length
// - gap segment closes every field
// - soft sectoring starts sectors at address marks
// - locate sectors/fields, count octets, drive gates
// - write and acquire PLO, bit, octet sync
// - up to three fields, one organization
// - list length word excludes itself, equals thirty
// - fixed-block layout only for type code one
// - flag octet bit assignments as defined
// - accept one to 256 sectors per track
// - fixed-sector drive inserts sector count on read
// - all-ones field sizes: drive computes sizes
// - all-ones sector count: drive computes, with overhead
// - drive supplies physical octets per sector
// - header verify skips given leading octets
// - field length up to 65536, includes check octets
// - turnaround delay per field, zero allowed
// - gap exceeds turnaround by fixed drive extra
// - list octet positions as defined
// - hard sectoring counts octets from index
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
module fbf_drive #(
	parameter int GATE_DLY = 8,
	parameter int PLO_LEN = 12,
	parameter int GAP_EXTRA = 16,
	parameter int TRACK_OCTETS = 20160,
	parameter int FIXED_SECTORS = 0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	fbf_if.drive link,
	input wire logic indexPin,
	input wire logic addrMarkPin,
	input wire logic [7:0] diskRdOctet,
	output logic readGate,
	output logic writeGate,
	output logic [7:0] diskWrOctet,
	output logic aligned
);
	typedef enum logic [7:0] {
		SEG_IDLE = 8'h01, SEG_WAIT = 8'h02, SEG_GATE = 8'h04, SEG_PLO = 8'h08,
		SEG_SYNC = 8'h10, SEG_DATA = 8'h20, SEG_PAD = 8'h40, SEG_GAP = 8'h80
	} seg_type;
	typedef enum logic [4:0] {
		CALC_IDLE = 5'h01, CALC_SECT = 5'h02, CALC_PHYS = 5'h04, CALC_SIZE = 5'h08,
		CALC_CHECK = 5'h10
	} calc_type;
	localparam logic [31:0] OVH = 32'(GATE_DLY + PLO_LEN + fbf_pkg::SYNC_SEG
		+ fbf_pkg::PAD_SEG + GAP_EXTRA);

	logic [7:0] list_q [fbf_pkg::LIST_OCTETS];
	calc_type calc_q;
	seg_type seg_q;
	logic fmtOk_q;
	logic divStart_q;
	logic [31:0] divNum_q;
	logic [31:0] divDen_q;
	logic divDone;
	logic [31:0] divQuot;
	logic [15:0] lenVal, secVal, skipVal, nfVal;
	logic [31:0] physVal, secLen, dlySum;
	logic [31:0] sizeVal [fbf_pkg::MAX_FIELDS];
	logic [15:0] dlyVal [fbf_pkg::MAX_FIELDS];
	logic sizesUnspec;
	logic [1:0] pinS1_q, pinS2_q, pinS3_q;
	logic idxRise, markRise, sectorStart, segEnd, sel, lastField;
	logic [31:0] secPos_q, segCnt_q, segLen;
	logic [8:0] secNum_q;
	logic [1:0] field_q;
	logic [7:0] flags;

	// every multi-octet value is held most significant octet first
	assign lenVal = {list_q[fbf_pkg::OFS_LEN], list_q[fbf_pkg::OFS_LEN+1]};
	assign secVal = {list_q[fbf_pkg::OFS_SECTORS], list_q[fbf_pkg::OFS_SECTORS+1]};
	assign physVal = {list_q[fbf_pkg::OFS_PHYS], list_q[fbf_pkg::OFS_PHYS+1],
		list_q[fbf_pkg::OFS_PHYS+2], list_q[fbf_pkg::OFS_PHYS+3]};
	assign skipVal = {list_q[fbf_pkg::OFS_SKIP], list_q[fbf_pkg::OFS_SKIP+1]};
	assign nfVal = {list_q[fbf_pkg::OFS_FIELDS], list_q[fbf_pkg::OFS_FIELDS+1]};
	assign flags = list_q[fbf_pkg::OFS_FLAG];

	always_comb begin
		secLen = '0;
		dlySum = '0;
		sizesUnspec = 1'b1;
		for (int i = 0; i < fbf_pkg::MAX_FIELDS; i++) begin
			sizeVal[i] = {list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i],
				list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i+1],
				list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i+2],
				list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i+3]};
			dlyVal[i] = {list_q[fbf_pkg::OFS_DLY0+fbf_pkg::FIELD_STRIDE*i],
				list_q[fbf_pkg::OFS_DLY0+fbf_pkg::FIELD_STRIDE*i+1]};
			if (16'(i) < nfVal) begin
				// drive overhead octets are part of each field
				secLen = secLen + sizeVal[i] + OVH + 32'(dlyVal[i]);
				dlySum = dlySum + 32'(dlyVal[i]);
				if (sizeVal[i] != fbf_pkg::UNSPEC32) begin
					sizesUnspec = 1'b0;
				end
			end
		end
	end

	fbf_divider #(.W(32)) divider (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(divStart_q),
		.num(divNum_q),
		.den(divDen_q),
		.done(divDone),
		.quot(divQuot)
	);

	assign link.listReady = (calc_q == CALC_IDLE);
	assign link.fmtOk = fmtOk_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			calc_q <= CALC_IDLE;
			fmtOk_q <= 1'b0;
			divStart_q <= 1'b0;
			divNum_q <= '0;
			divDen_q <= '0;
			for (int i = 0; i < fbf_pkg::LIST_OCTETS; i++) begin
				list_q[i] <= 8'h00;
			end
		end else if (ce) begin
			divStart_q <= 1'b0;
			case (calc_q)
				CALC_IDLE: begin
					if (link.listValid && link.listWrite) begin
						list_q[link.listAddr] <= link.listWdata;
					end
					if (link.listDone) begin
						fmtOk_q <= 1'b0;
						divNum_q <= 32'(TRACK_OCTETS);
						// anything other than length thirty and type one is not laid out
						if (lenVal != fbf_pkg::LIST_LEN || list_q[fbf_pkg::OFS_TYPE] != fbf_pkg::TYPE_FIXED) begin
							calc_q <= CALC_IDLE;
						end else if (secVal == fbf_pkg::UNSPEC16) begin
							divDen_q <= secLen;
							divStart_q <= 1'b1;
							calc_q <= CALC_SECT;
						end else if (sizesUnspec) begin
							divDen_q <= 32'(secVal);
							divStart_q <= 1'b1;
							calc_q <= CALC_PHYS;
						end else begin
							{list_q[6], list_q[7], list_q[8], list_q[9]} <= secLen;
							calc_q <= CALC_CHECK;
						end
					end
				end
				CALC_SECT: begin
					if (divDone) begin
						{list_q[4], list_q[5]} <= (divQuot > 32'(fbf_pkg::MAX_SECTORS)) ?
							16'(fbf_pkg::MAX_SECTORS) : divQuot[15:0];
						{list_q[6], list_q[7], list_q[8], list_q[9]} <= secLen;
						calc_q <= CALC_CHECK;
					end
				end
				CALC_PHYS: begin
					if (divDone) begin
						{list_q[6], list_q[7], list_q[8], list_q[9]} <= divQuot;
						divNum_q <= divQuot - 32'(32'(nfVal) * OVH) - dlySum;
						divDen_q <= 32'(nfVal);
						divStart_q <= 1'b1;
						calc_q <= CALC_SIZE;
					end
				end
				CALC_SIZE: begin
					if (divDone) begin
						for (int i = 0; i < fbf_pkg::MAX_FIELDS; i++) begin
							if (16'(i) < nfVal) begin
								{list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i],
									list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i+1],
									list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i+2],
									list_q[fbf_pkg::OFS_SIZE0+fbf_pkg::FIELD_STRIDE*i+3]}
									<= divQuot;
							end
						end
						calc_q <= CALC_CHECK;
					end
				end
				CALC_CHECK: begin
					list_q[fbf_pkg::OFS_FLAG][fbf_pkg::FLG_INIT] <= 1'b1;
					fmtOk_q <= secVal >= 16'h0001 && secVal <= 16'(fbf_pkg::MAX_SECTORS)
						&& nfVal >= 16'h0001 && nfVal <= 16'(fbf_pkg::MAX_FIELDS);
					calc_q <= CALC_IDLE;
				end
				default: calc_q <= CALC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.listRvalid <= 1'b0;
			link.listRdata <= 8'h00;
		end else if (ce) begin
			link.listRvalid <= link.listValid && !link.listWrite && calc_q == CALC_IDLE;
			if (FIXED_SECTORS != 0 && link.listAddr == 5'(fbf_pkg::OFS_SECTORS)) begin
				link.listRdata <= 8'(FIXED_SECTORS >> 8);
			end else if (FIXED_SECTORS != 0 && link.listAddr == 5'(fbf_pkg::OFS_SECTORS + 1)) begin
				link.listRdata <= 8'(FIXED_SECTORS);
			end else begin
				link.listRdata <= list_q[link.listAddr];
			end
		end
	end

	// index and address mark are pins: two flops before any use
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinS1_q <= '0;
			pinS2_q <= '0;
			pinS3_q <= '0;
		end else if (ce) begin
			pinS1_q <= {addrMarkPin, indexPin};
			pinS2_q <= pinS1_q;
			pinS3_q <= pinS2_q;
		end
	end
	assign idxRise = pinS2_q[0] && !pinS3_q[0];
	assign markRise = pinS2_q[1] && !pinS3_q[1];

	assign sectorStart = fmtOk_q && ((flags[fbf_pkg::FLG_HARD] && (idxRise
		|| (secPos_q + 1 >= physVal && 16'(secNum_q) + 1 < secVal)))
		|| (flags[fbf_pkg::FLG_SOFT] && markRise));
	assign lastField = 16'(field_q) + 1 >= nfVal;

	always_comb begin
		case (seg_q)
			SEG_GATE: segLen = 32'(GATE_DLY);
			SEG_PLO: segLen = 32'(PLO_LEN);
			SEG_SYNC: segLen = 32'(fbf_pkg::SYNC_SEG);
			SEG_DATA: segLen = sizeVal[field_q];
			SEG_PAD: segLen = 32'(fbf_pkg::PAD_SEG);
			SEG_GAP: segLen = 32'(dlyVal[field_q]) + 32'(GAP_EXTRA);
			default: segLen = '0;
		endcase
	end
	assign segEnd = segCnt_q + 1 >= segLen;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seg_q <= SEG_IDLE;
			segCnt_q <= '0;
			secPos_q <= '0;
			secNum_q <= '1;
			field_q <= '0;
		end else if (ce) begin
			secPos_q <= secPos_q + 1;
			if (!fmtOk_q) begin
				seg_q <= SEG_IDLE;
				secNum_q <= '1; // no hard sector until the next index
			end else if (sectorStart) begin
				seg_q <= SEG_GATE;
				segCnt_q <= '0;
				secPos_q <= '0;
				field_q <= '0;
				secNum_q <= idxRise ? 9'h000 : secNum_q + 1'b1;
			end else begin
				segCnt_q <= segEnd ? 32'h0000_0000 : segCnt_q + 1;
				case (seg_q)
					SEG_IDLE: seg_q <= SEG_WAIT;
					SEG_WAIT: seg_q <= SEG_WAIT;
					SEG_GATE: if (segEnd) seg_q <= SEG_PLO;
					SEG_PLO: if (segEnd) seg_q <= SEG_SYNC;
					SEG_SYNC: if (segEnd) seg_q <= SEG_DATA;
					SEG_DATA: if (segEnd) seg_q <= SEG_PAD;
					SEG_PAD: if (segEnd) seg_q <= SEG_GAP;
					SEG_GAP: begin
						if (segEnd) begin
							seg_q <= lastField ? SEG_WAIT : SEG_GATE;
							field_q <= lastField ? field_q : field_q + 1'b1;
						end
					end
					default: seg_q <= SEG_IDLE;
				endcase
			end
		end
	end

	assign sel = link.cmdOp != fbf_pkg::CMD_NONE
		&& (flags[fbf_pkg::FLG_SECTOR] || link.cmdField == field_q);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			writeGate <= 1'b0;
			readGate <= 1'b0;
			diskWrOctet <= 8'h00;
			aligned <= 1'b0;
			link.rdValid <= 1'b0;
			link.rdOctet <= 8'h00;
			link.cmpEn <= 1'b0;
			link.slaveIn <= 1'b0;
		end else if (ce) begin
			writeGate <= sel && link.cmdOp == fbf_pkg::CMD_WRITE
				&& (seg_q & (SEG_GATE | SEG_PLO | SEG_SYNC | SEG_DATA | SEG_PAD)) != '0;
			// read gate waits out the splice delay, then spans PLO, sync and data
			readGate <= sel && link.cmdOp != fbf_pkg::CMD_WRITE
				&& (seg_q & (SEG_PLO | SEG_SYNC | SEG_DATA)) != '0;
			case (seg_q)
				SEG_PLO: diskWrOctet <= fbf_pkg::PLO_OCTET;
				SEG_SYNC: diskWrOctet <= fbf_pkg::SYNC_OCTET;
				SEG_DATA: diskWrOctet <= link.wrData;
				default: diskWrOctet <= fbf_pkg::PAD_OCTET;
			endcase
			if ((seg_q & (SEG_PLO | SEG_SYNC)) != '0 && readGate
				&& diskRdOctet == fbf_pkg::SYNC_OCTET) begin
				aligned <= 1'b1;
			end else if ((seg_q & (SEG_GATE | SEG_WAIT | SEG_IDLE)) != '0) begin
				aligned <= 1'b0;
			end
			link.rdValid <= readGate && aligned && seg_q == SEG_DATA;
			link.rdOctet <= diskRdOctet;
			link.cmpEn <= readGate && aligned && seg_q == SEG_DATA
				&& link.cmdOp == fbf_pkg::CMD_VERIFY && field_q == 2'h0
				&& segCnt_q >= 32'(skipVal);
			link.slaveIn <= sel && seg_q == SEG_DATA;
		end
	end
endmodule

// File: hw/fbf_ctrl.sv
// controller end: APB registers, parameter list load and read-back, data command
`timescale 1ns/10ps
module fbf_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fbf_if.ctrl link
);
	logic [7:0] shadow_q [fbf_pkg::LIST_OCTETS];
	logic [5:0] cmd_q;
	logic [7:0] wrData_q;
	logic [8:0] rdLast_q;
	logic busy_q, load_q, waitR_q, done_q;
	logic [4:0] idx_q;
	logic apbWr, mapped;
	logic [2:0] word;

	assign word = paddr[4:2];
	assign mapped = paddr[1:0] == 2'b00 && (paddr < fbf_pkg::REG_CMD
		|| paddr == fbf_pkg::REG_CMD || paddr == fbf_pkg::REG_STAT
		|| paddr == fbf_pkg::REG_WDATA || paddr == fbf_pkg::REG_RDATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign apbWr = psel && penable && pwrite && mapped && ce;

	assign link.listValid = busy_q && !waitR_q;
	assign link.listWrite = load_q;
	assign link.listAddr = idx_q;
	assign link.listWdata = shadow_q[idx_q];
	assign link.listDone = done_q;
	assign link.cmdOp = cmd_q[1:0];
	assign link.cmdField = cmd_q[3:2];
	assign link.wrData = wrData_q;

	// read data is registered in the setup cycle so access needs no wait state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			if (!mapped || pwrite) begin
				prdata <= 32'h0000_0000;
			end else if (paddr < fbf_pkg::REG_CMD) begin
				prdata <= {shadow_q[{word, 2'b00}], shadow_q[{word, 2'b01}],
					shadow_q[{word, 2'b10}], shadow_q[{word, 2'b11}]};
			end else if (paddr == fbf_pkg::REG_CMD) begin
				prdata <= {26'h000_0000, cmd_q};
			end else if (paddr == fbf_pkg::REG_STAT) begin
				prdata <= {29'h0000_0000, link.slaveIn, link.fmtOk,
					busy_q || done_q || !link.listReady};
			end else if (paddr == fbf_pkg::REG_WDATA) begin
				prdata <= {24'h00_0000, wrData_q};
			end else begin
				prdata <= {23'h00_0000, rdLast_q};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_q <= '0;
			wrData_q <= 8'h00;
			rdLast_q <= '0;
		end else if (ce) begin
			cmd_q[fbf_pkg::CMD_GO_READ:fbf_pkg::CMD_GO_LOAD] <= 2'b00;
			if (apbWr && paddr == fbf_pkg::REG_CMD) begin
				cmd_q <= pwdata[5:0];
			end
			if (apbWr && paddr == fbf_pkg::REG_WDATA) begin
				wrData_q <= pwdata[7:0];
			end
			if (link.rdValid) begin
				rdLast_q <= {link.cmpEn, link.rdOctet};
			end
		end
	end

	// octets go out in list order, so multi-octet values travel high octet first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			load_q <= 1'b0;
			waitR_q <= 1'b0;
			done_q <= 1'b0;
			idx_q <= '0;
			for (int i = 0; i < fbf_pkg::LIST_OCTETS; i++) begin
				shadow_q[i] <= 8'h00;
			end
		end else if (ce) begin
			done_q <= 1'b0;
			if (!busy_q) begin
				if (apbWr && paddr < fbf_pkg::REG_CMD) begin
					{shadow_q[{word, 2'b00}], shadow_q[{word, 2'b01}],
						shadow_q[{word, 2'b10}], shadow_q[{word, 2'b11}]} <= pwdata;
				end
				if (apbWr && paddr == fbf_pkg::REG_CMD
					&& (pwdata[fbf_pkg::CMD_GO_LOAD] || pwdata[fbf_pkg::CMD_GO_READ])) begin
					busy_q <= 1'b1;
					load_q <= pwdata[fbf_pkg::CMD_GO_LOAD];
					idx_q <= '0;
				end
			end else if (load_q) begin
				if (link.listReady) begin
					idx_q <= idx_q + 1'b1;
					if (idx_q == 5'(fbf_pkg::LIST_OCTETS - 1)) begin
						busy_q <= 1'b0;
						done_q <= 1'b1;
					end
				end
			end else begin
				if (!waitR_q && link.listReady) begin
					waitR_q <= 1'b1;
				end
				if (link.listRvalid) begin
					shadow_q[idx_q] <= link.listRdata;
					waitR_q <= 1'b0;
					idx_q <= idx_q + 1'b1;
					busy_q <= idx_q != 5'(fbf_pkg::LIST_OCTETS - 1);
				end
			end
		end
	end
endmodule

// File: tb/fbf_chk.sv
// concurrent checks on the controller-to-drive parameter list link
`timescale 1ns/10ps
module fbf_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic listValid,
	input wire logic listWrite,
	input wire logic [4:0] listAddr,
	input wire logic [7:0] listWdata,
	input wire logic listReady,
	input wire logic listRvalid,
	input wire logic [7:0] listRdata,
	input wire logic listDone,
	input wire logic slaveIn,
	input wire logic fmtOk
);
	logic [4:0] rdAddr_q;
	logic [23:0] head_q;
	logic good_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdAddr_q <= 5'h00;
		end else if (listValid && listReady && !listWrite) begin
			rdAddr_q <= listAddr;
		end
	end
	// loads arrive in address order, so the first three octets shift in
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			head_q <= 24'h00_0000;
		end else if (listValid && listReady && listWrite && listAddr < 5'h03) begin
			head_q <= {head_q[15:0], listWdata};
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			good_q <= 1'b0;
		end else if (listDone) begin
			good_q <= head_q == {fbf_pkg::LIST_LEN, fbf_pkg::TYPE_FIXED};
		end
	end
	sequence s_rdReq;
		listValid && listReady && !listWrite;
	endsequence
	sequence s_rdAns;
		listRvalid ##1 !listRvalid;
	endsequence
	sequence s_back(int a);
		listRvalid && fmtOk && rdAddr_q == a;
	endsequence
	property p_rdAnswer;
		s_rdReq |=> s_rdAns;
	endproperty
	property p_readyBack;
		listDone |=> ##[0:100] listReady;
	endproperty
	property p_goodOnly;
		$rose(fmtOk) |-> good_q;
	endproperty
	property p_lenBack;
		s_back(1) |-> listRdata == fbf_pkg::LIST_LEN[7:0];
	endproperty
	property p_typeBack;
		s_back(2) |-> listRdata == fbf_pkg::TYPE_FIXED;
	endproperty
	property p_initBack;
		s_back(3) |-> listRdata[fbf_pkg::FLG_INIT];
	endproperty
	property p_secRange;
		s_back(4) |-> listRdata <= 8'h01;
	endproperty
	property p_slave;
		slaveIn |-> fmtOk;
	endproperty
	a_rdAnswer: assert property (p_rdAnswer) else $error("list read not answered");
	a_readyBack: assert property (p_readyBack) else $error("drive stuck busy");
	a_goodOnly: assert property (p_goodOnly) else $error("bad list accepted");
	a_lenBack: assert property (p_lenBack) else $error("length octet wrong");
	a_typeBack: assert property (p_typeBack) else $error("type octet wrong");
	a_initBack: assert property (p_initBack) else $error("init flag clear");
	a_secRange: assert property (p_secRange) else $error("sector count too big");
	a_slave: assert property (p_slave) else $error("transfer without format");
endmodule

// File: tb/tb.sv
// self-checking bench: controller and drive joined, driven over APB
`timescale 1ns/10ps
module tb;
	localparam int GATE = 8;
	localparam int PLO = 12;
	localparam int TRK = 400;
	localparam int OVH = GATE + PLO + 1 + 2 + 16;
	logic clk, rst_n, psel, penable, pwrite, pslverr, pready, err;
	logic indexPin, addrMarkPin, readGate, writeGate, aligned;
	logic [7:0] paddr, diskRdOctet, diskWrOctet, wd;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [31:0] sz [3];
	logic [15:0] dl [3];
	logic [7:0] lst [32];
	logic [7:0] bk [32];
	logic [7:0] oct [256];
	int n_mismatch, n_tests, cnt, nrv, ncmp;
	fbf_if link();
	fbf_ctrl u_fbf_ctrl(.clk(clk), .rst_n(rst_n), .ce(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	fbf_drive #(.GATE_DLY(GATE), .PLO_LEN(PLO), .GAP_EXTRA(16), .TRACK_OCTETS(TRK))
		u_fbf_drive(.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link), .indexPin(indexPin),
		.addrMarkPin(addrMarkPin), .diskRdOctet(diskRdOctet), .readGate(readGate),
		.writeGate(writeGate), .diskWrOctet(diskWrOctet), .aligned(aligned));
	fbf_chk u_fbf_chk(.clk(clk), .rst_n(rst_n), .listValid(link.listValid),
		.listWrite(link.listWrite), .listAddr(link.listAddr), .listWdata(link.listWdata),
		.listReady(link.listReady), .listRvalid(link.listRvalid), .listRdata(link.listRdata),
		.listDone(link.listDone), .slaveIn(link.slaveIn), .fmtOk(link.fmtOk));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int secOct(int n);
		int o;
		o = 0;
		for (int f = 0; f < n; f++) o += OVH + int'(sz[f]) + int'(dl[f]);
		return o;
	endfunction
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int t;
		t = 0;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		check("pready", 1, pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic poll(logic [31:0] m, logic [31:0] v);
		int t;
		t = 0;
		repeat (4) @(posedge clk);
		do begin
			apb(1'b0, fbf_pkg::REG_STAT, 32'h0000_0000);
			t++;
		end while ((rd & m) !== v && t < 80);
		check("status", v, rd & m);
	endtask
	task automatic mk(logic [15:0] len, logic [7:0] typ, logic [7:0] flg, logic [15:0] sec,
		int n, int skip);
		lst = '{default: 8'hff};
		{lst[0], lst[1]} = len;
		lst[2] = typ;
		lst[3] = flg;
		{lst[4], lst[5]} = sec;
		{lst[10], lst[11]} = 16'(skip);
		{lst[12], lst[13]} = 16'(n);
		for (int f = 0; f < 3; f++) begin
			{lst[14 + 6 * f], lst[15 + 6 * f], lst[16 + 6 * f], lst[17 + 6 * f]} = sz[f];
			{lst[18 + 6 * f], lst[19 + 6 * f]} = dl[f];
		end
		for (int k = 0; k < 32; k += 4) begin
			apb(1'b1, 8'(k), {lst[k], lst[k + 1], lst[k + 2], lst[k + 3]});
		end
		apb(1'b1, fbf_pkg::REG_CMD, 32'h0000_0010);
		poll(32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic back();
		apb(1'b1, fbf_pkg::REG_CMD, 32'h0000_0020);
		poll(32'h0000_0001, 32'h0000_0000);
		for (int k = 0; k < 32; k += 4) begin
			apb(1'b0, 8'(k), 32'h0000_0000);
			{bk[k], bk[k + 1], bk[k + 2], bk[k + 3]} = rd;
		end
	endtask
	// one tail cycle is sampled only if the gate rose within two cycles of the pin pulse ending; read octets end with the gate
	task automatic grab(logic wr, logic mark);
		int t;
		t = 0;
		cnt = 0;
		nrv = 0;
		ncmp = 0;
		indexPin <= !mark;
		addrMarkPin <= mark;
		repeat (3) @(posedge clk);
		indexPin <= 1'b0;
		addrMarkPin <= 1'b0;
		while ((wr ? writeGate : readGate) !== 1'b1 && t < 2000) begin
			@(posedge clk);
			t++;
		end
		while (((wr ? writeGate : readGate) === 1'b1 || t < 3) && cnt < 255) begin
			if ((wr ? writeGate : readGate) !== 1'b1) t = 0;
			oct[cnt] = diskWrOctet;
			nrv += int'(link.rdValid === 1'b1);
			ncmp += int'(link.cmpEn === 1'b1);
			cnt += int'((wr ? writeGate : readGate) === 1'b1);
			t += int'((wr ? writeGate : readGate) !== 1'b1) * 4;
			@(posedge clk);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		$display("unexpected watchdog expired");
		results();
	end
	initial begin
		int n, s, e;
		seed = 32'h0001_69be;
		{rst_n, psel, penable, pwrite, indexPin, addrMarkPin} = 6'h00;
		{paddr, diskRdOctet, pwdata} = 48'h0000_0000_0000;
		sz = '{32'h0000_0010, 32'h0000_0000, 32'h0000_0000};
		dl = '{16'h0000, 16'h0000, 16'h0000};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 2; i++) begin
			mk(i ? 16'h001f : 16'h001e, i ? 8'h01 : 8'h02, 8'h06, 16'h0002, 1, 0);
			check("fmtOk bad list", 32'h0000_0000, {31'h0, rd[1]});
		end
		$display("test bad lists done");
		apb(1'b0, 8'h30, 32'h0000_0000);
		check("unmapped error", 32'h0000_0001, {31'h0, err});
		check("unmapped data", 32'h0000_0000, rd);
		$display("test unmapped done");
		for (int r = 0; r < 6; r++) begin
			n = int'(rnd() % 3) + 1;
			s = r < 3 ? 0 : int'(rnd() % 3) + 2;
			n = r < 3 ? n : (n + 1) / 2;
			for (int f = 0; f < 3; f++) begin
				sz[f] = r >= 3 ? fbf_pkg::UNSPEC32 : f < n ? rnd() % 40 + 1 : 32'h0000_0000;
				dl[f] = f < n ? 16'(rnd() % 8) : 16'h0000;
			end
			mk(16'h001e, 8'h01, 8'h06, r < 3 ? fbf_pkg::UNSPEC16 : 16'(s), n, 0);
			back();
			check("head", 32'h001e_0186, {bk[0], bk[1], bk[2], bk[3]});
			if (r < 3) begin
				s = TRK / secOct(n);
				check("sectors", 32'(s), {16'h0, bk[4], bk[5]});
			end else begin
				e = TRK / s - n * OVH;
				for (int f = 0; f < n; f++) e -= int'(dl[f]);
				for (int f = 0; f < n; f++) begin
					check("size", 32'(e / n), {bk[14+6*f], bk[15+6*f], bk[16+6*f], bk[17+6*f]});
				end
			end
			check("phys", 32'(r < 3 ? secOct(n) : TRK / s), {bk[6], bk[7], bk[8], bk[9]});
		end
		$display("test computed values done");
		sz = '{rnd() % 20 + 4, 32'h0000_0000, 32'h0000_0000};
		dl = '{16'h0000, 16'h0000, 16'h0000};
		wd = 8'(rnd());
		mk(16'h001e, 8'h01, 8'h06, 16'h0002, 1, 0);
		apb(1'b1, fbf_pkg::REG_WDATA, {24'h0, wd});
		apb(1'b1, fbf_pkg::REG_CMD, {30'h0, fbf_pkg::CMD_WRITE});
		grab(1'b1, 1'b0);
		check("write gate span", 32'(GATE + PLO + 3) + sz[0], 32'(cnt));
		check("sync octet", {24'h0, fbf_pkg::SYNC_OCTET}, {24'h0, oct[GATE + PLO]});
		check("data octet", {24'h0, wd}, {24'h0, oct[GATE + PLO + 1]});
		check("pad octet", {24'h0, fbf_pkg::PAD_OCTET}, {24'h0, oct[cnt - 1]});
		$display("test hard write done");
		mk(16'h001e, 8'h01, 8'h0a, 16'h0002, 1, 2);
		diskRdOctet <= fbf_pkg::SYNC_OCTET;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, fbf_pkg::REG_CMD, {30'h0, i ? fbf_pkg::CMD_VERIFY : fbf_pkg::CMD_READ});
			grab(1'b0, 1'b1);
			check("read octets", sz[0], 32'(nrv));
			check("compared octets", i ? sz[0] - 2 : 32'h0, 32'(ncmp));
			apb(1'b0, fbf_pkg::REG_RDATA, 32'h0000_0000);
			check("last octet", {23'h0, i[0], fbf_pkg::SYNC_OCTET}, rd);
		end
		apb(1'b1, fbf_pkg::REG_CMD, {30'h0, fbf_pkg::CMD_NONE});
		$display("test soft read done");
		results();
	end
endmodule
